// [src/keli_ctrl.sv]
`timescale 1ns/1ps
// How it works
// RULE_01: pin joins detector only when connect set
// RULE_02: pin must be seen deasserted first
// RULE_03: falling edge is 1 then 0
// RULE_04: rising edge is 0 then 1
// RULE_05: any enabled edge sets shared flag
// RULE_06: level mode edge needs others deasserted
// RULE_07: level mode holds flag while asserted
// RULE_08: deep stop bypasses detector, wakes on level
// RULE_09: irq while flag and enable set
// RULE_10: edge mode ack always clears flag; here a new event in the same cycle wins and keeps it set
// RULE_11: pins 3..0 falling, others per polarity
// RULE_12: ack bit is write-only, reads zero
// RULE_13: reset clears flag and all controls
module keli_ctrl
    import keli_pkg::*;
#(
    parameter int N_PINS = KELI_MAX_PINS
) (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // ahb-lite slave
    input keli_ahb_req_type ahb_req_i,
    input logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // keyboard pins and power state
    input logic [N_PINS-1:0] key_input_pin_i,
    input logic deep_stop_state_i,
    // requests
    output logic key_irq_o,
    output logic irq_o,
    output logic wake_o
);

    // polarity bits only exist for pins 4..7
    if (N_PINS <= KELI_FIXED_PINS || N_PINS > KELI_MAX_PINS) begin : g_chk
        $error("keli_ctrl: N_PINS must be 5 to 8");
    end

    keli_state_type st_reg;
    keli_state_type st_next;

    logic [N_PINS-1:0] rise_vec;
    logic [N_PINS-1:0] lvl_vec;
    logic [N_PINS-1:0] edge_vec;
    logic any_edge;
    logic any_lvl;
    logic others_lvl;
    logic edge_evt;
    logic level_hold;
    logic flag_set;
    logic take;
    logic addr_hit;
    logic ack_wr;
    logic [KELI_EVT_W-1:0] evt_vec;

    // one detector per pin; fixed pins never select rising
    for (genvar i = 0; i < N_PINS; i++) begin : g_pin
        if (i < KELI_FIXED_PINS) begin : g_fix
            assign rise_vec[i] = 1'h0; // RULE_11
        end else begin : g_sel
            assign rise_vec[i] = st_reg.pol[i-KELI_FIXED_PINS]; // RULE_11
        end
        keli_pin_det keli_pin_det_i (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(key_input_pin_i[i]),
            .connect_i(st_reg.connect[i]),
            .rise_i(rise_vec[i]),
            .freeze_i(deep_stop_state_i),
            .asserted_o(lvl_vec[i]),
            .edge_o(edge_vec[i])
        );
    end

    // event qualification across all enabled pins
    always_comb begin
        any_edge = |edge_vec; // RULE_05
        any_lvl = |lvl_vec;
        others_lvl = |(lvl_vec & ~edge_vec);
        // in level mode an edge counts only if no other pin already holds
        if (st_reg.mode) begin
            edge_evt = any_edge & ~others_lvl; // RULE_06
        end else begin
            edge_evt = any_edge;
        end
        level_hold = st_reg.mode & any_lvl & ~deep_stop_state_i; // RULE_07
        flag_set = edge_evt | level_hold;
    end

    // bus decode: zero-wait slave, data phase completes at once
    assign take = ahb_req_i.hsel & ahb_req_i.hready
        & ahb_req_i.htrans[KELI_HTRANS_ACT];
    assign addr_hit = (ahb_req_i.haddr[31:4] == 28'h000_0000);
    assign ack_wr = st_reg.wr_pend & st_reg.wr_hit
        & (st_reg.wr_idx == KELI_CTRL_IDX) & hwdata_i[KELI_ACK_BIT];
    assign evt_vec = {deep_stop_state_i & any_lvl, flag_set};

    // next state: register writes, flag, status and read data
    always_comb begin
        st_next = st_reg;
        // data phase of a write lands here, one cycle after address phase
        if (st_reg.wr_pend && st_reg.wr_hit) begin
            unique case (st_reg.wr_idx)
                KELI_CTRL_IDX: begin
                    st_next.pol = hwdata_i[KELI_POL_LSB +: KELI_POL_W];
                    st_next.irq_en = hwdata_i[KELI_IE_BIT];
                    st_next.mode = hwdata_i[KELI_MODE_BIT];
                end
                KELI_CONNECT_IDX: begin
                    st_next.connect = hwdata_i[KELI_MAX_PINS-1:0]; // RULE_01
                end
                KELI_STATUS_IDX: begin
                    // write one to clear
                    st_next.status = st_reg.status
                        & ~hwdata_i[KELI_EVT_W-1:0];
                end
                KELI_MASK_IDX: begin
                    st_next.mask = hwdata_i[KELI_EVT_W-1:0];
                end
            endcase
        end
        // a new event beats an acknowledge in the same cycle
        if (flag_set) begin
            st_next.flag = 1'h1; // RULE_05 RULE_07
        end else if (ack_wr) begin
            st_next.flag = 1'h0; // RULE_10
        end
        st_next.status = st_next.status | evt_vec;
        // address phase: remember the write, prepare read data
        st_next.wr_pend = take & ahb_req_i.hwrite;
        st_next.wr_hit = addr_hit;
        st_next.wr_idx = ahb_req_i.haddr[3:2];
        st_next.rdata = 32'h0000_0000;
        if (take && !ahb_req_i.hwrite && addr_hit) begin
            unique case (ahb_req_i.haddr[3:2])
                KELI_CTRL_IDX: begin
                    st_next.rdata[KELI_POL_LSB +: KELI_POL_W] = st_reg.pol;
                    st_next.rdata[KELI_FLAG_BIT] = st_reg.flag;
                    st_next.rdata[KELI_ACK_BIT] = 1'h0; // RULE_12
                    st_next.rdata[KELI_IE_BIT] = st_reg.irq_en;
                    st_next.rdata[KELI_MODE_BIT] = st_reg.mode;
                end
                KELI_CONNECT_IDX: begin
                    st_next.rdata[KELI_MAX_PINS-1:0] = st_reg.connect;
                end
                KELI_STATUS_IDX: begin
                    st_next.rdata[KELI_EVT_W-1:0] = st_reg.status;
                end
                KELI_MASK_IDX: begin
                    st_next.rdata[KELI_EVT_W-1:0] = st_reg.mask;
                end
            endcase
        end
    end

    // synchronous reset puts every control bit inactive
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= KELI_STATE_RST; // RULE_13
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign hrdata_o = st_reg.rdata;
    assign hreadyout_o = 1'h1;
    assign hresp_o = 1'h0;
    assign key_irq_o = st_reg.flag & st_reg.irq_en; // RULE_09
    assign irq_o = |(st_reg.status & st_reg.mask);
    // wake path is a plain level; it must work with the clock stopped
    assign wake_o = deep_stop_state_i & any_lvl; // RULE_08

    // all checks run on the bus clock and rest while reset is low, except reset_quiet_a and reset_controls_a, which stay active in reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    flag_on_edge_a: assert property ( // RULE_05
        edge_evt |=> st_reg.flag)
        else $error("edge event did not set flag");

    mode_qualify_a: assert property ( // RULE_06
        (st_reg.mode && others_lvl) |-> !edge_evt)
        else $error("level mode edge with another pin asserted");

    level_hold_a: assert property ( // RULE_07
        (st_reg.mode && any_lvl && !deep_stop_state_i && ack_wr)
            |=> st_reg.flag)
        else $error("ack cleared flag while level held");

    stop_bypass_a: assert property ( // RULE_08
        deep_stop_state_i |-> (edge_vec == '0) && (wake_o == any_lvl))
        else $error("detector active or no wake in deep stop");

    irq_request_a: assert property ( // RULE_09
        (st_reg.flag && st_reg.irq_en) |-> key_irq_o)
        else $error("irq missing while flag and enable set");

    irq_quiet_a: assert property ( // RULE_09
        !st_reg.flag |-> !key_irq_o)
        else $error("irq without flag");

    ack_clear_a: assert property ( // RULE_10
        (ack_wr && !st_reg.mode && !flag_set) |=> !st_reg.flag)
        else $error("ack did not clear flag in edge mode");

    gate_pins_a: assert property ( // RULE_01
        (st_reg.connect[N_PINS-1:0] == '0) |-> (lvl_vec == '0)
        && (edge_vec == '0))
        else $error("disconnected pin reached detector");

    fixed_pol_a: assert property ( // RULE_11
        lvl_vec[0] == (st_reg.connect[0] & ~key_input_pin_i[0]))
        else $error("pin 0 not low sensitive");

    ack_reads_zero_a: assert property ( // RULE_12
        (take && !ahb_req_i.hwrite && addr_hit
            && ahb_req_i.haddr[3:2] == KELI_CTRL_IDX)
            |=> hrdata_o[KELI_ACK_BIT] == 1'h0
            && hrdata_o[KELI_FLAG_BIT] == $past(st_reg.flag))
        else $error("ack bit read back nonzero");

    reset_quiet_a: assert property ( // RULE_13
        @(posedge clk_i) disable iff (1'h0)
        !rst_n_i |=> !key_irq_o && !irq_o && !st_reg.flag)
        else $error("request active after reset");

    // flag and status bookkeeping; the flag may only move when an event
    // or an acknowledge says so
    flag_needs_cause_a: assert property ( // RULE_05
        (!st_reg.flag && !flag_set) |=> !st_reg.flag)
        else $error("flag set without an event");

    flag_sticky_a: assert property ( // RULE_10
        (st_reg.flag && !ack_wr) |=> st_reg.flag)
        else $error("flag dropped without an ack");

    status_key_a: assert property ( // RULE_05
        flag_set |=> st_reg.status[KELI_EVT_KEY])
        else $error("key event missing from status");

    mode_edge_only_a: assert property ( // RULE_10
        (!st_reg.mode && !edge_evt) |-> !flag_set)
        else $error("level held flag in edge-only mode");

    level_mode_flag_a: assert property ( // RULE_07
        (st_reg.mode && any_lvl && !deep_stop_state_i) |=> st_reg.flag)
        else $error("flag not held in level mode");

    wake_status_a: assert property ( // RULE_08
        (deep_stop_state_i && any_lvl) |=> st_reg.status[KELI_EVT_WAKE])
        else $error("wake missing from status");

    stop_freeze_flag_a: assert property ( // RULE_08
        (deep_stop_state_i && !st_reg.flag) |=> !st_reg.flag)
        else $error("flag set while detector bypassed");

    irq_disabled_a: assert property ( // RULE_09
        !st_reg.irq_en |-> !key_irq_o)
        else $error("irq while interrupt disabled");

    edge_needs_connect_a: assert property ( // RULE_01
        (edge_vec & ~st_reg.connect[N_PINS-1:0]) == '0)
        else $error("edge from a disconnected pin");

    connect_write_a: assert property ( // RULE_01
        (st_reg.wr_pend && st_reg.wr_hit
            && st_reg.wr_idx == KELI_CONNECT_IDX)
            |=> st_reg.connect == $past(hwdata_i[KELI_MAX_PINS-1:0]))
        else $error("connect write did not land");

    reset_controls_a: assert property ( // RULE_13
        @(posedge clk_i) disable iff (1'h0)
        !rst_n_i |=> st_reg.connect == '0 && !st_reg.irq_en
            && !st_reg.mode && st_reg.pol == '0 && st_reg.mask == '0)
        else $error("control bit active after reset");

    // every pin must show the level its polarity selects; fixed pins
    // have no polarity bit and always watch for low
    for (genvar p = 0; p < N_PINS; p++) begin : g_lvl_chk
        if (p < KELI_FIXED_PINS) begin : g_fix
            fixed_low_a: assert property ( // RULE_11
                @(posedge clk_i) disable iff (!rst_n_i)
                lvl_vec[p] == (st_reg.connect[p] && !key_input_pin_i[p]))
                else $error("fixed pin not low sensitive");
        end else begin : g_sel
            pol_follow_a: assert property ( // RULE_11
                @(posedge clk_i) disable iff (!rst_n_i)
                lvl_vec[p] == (st_reg.connect[p]
                    && key_input_pin_i[p] == st_reg.pol[p-KELI_FIXED_PINS]))
                else $error("pin does not follow its polarity bit");
        end
    end

    // main scenarios
    flag_cover_c: cover property (!st_reg.flag ##1 st_reg.flag);
    ack_cover_c: cover property (ack_wr && !flag_set ##1 !st_reg.flag);
    wake_cover_c: cover property (wake_o);
    hold_cover_c: cover property (level_hold && ack_wr);
    rise_cover_c: cover property (|(edge_vec & rise_vec));

endmodule : keli_ctrl

// [src/keli_pin_det.sv]
`timescale 1ns/1ps
module keli_pin_det
    import keli_pkg::*;
(
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // pin and its configuration
    input logic pin_i,
    input logic connect_i,
    input logic rise_i,
    input logic freeze_i,
    // detection results
    output logic asserted_o,
    output logic edge_o
);

    keli_det_state_type st_reg;
    keli_det_state_type st_next;

    // level at the selected polarity, gated by the connect bit
    assign asserted_o = connect_i & (rise_i ? pin_i : ~pin_i); // RULE_01

    // an edge needs a deasserted sample in the previous bus cycle
    assign edge_o = st_reg.armed & asserted_o & ~freeze_i; // RULE_02

    // arm only while connected and deasserted; a freeze disarms so that
    // a pin held asserted across deep stop gives no edge on exit
    always_comb begin
        st_next = st_reg;
        st_next.armed = connect_i & ~freeze_i & ~asserted_o; // RULE_03 RULE_04
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= KELI_DET_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    fall_edge_seen_a: assert property ( // RULE_03
        (edge_o && !rise_i && $past(!rise_i) && $past(connect_i))
            |-> ($past(pin_i) == 1'h1 && pin_i == 1'h0))
        else $error("falling edge without 1 then 0");

    rise_edge_seen_a: assert property ( // RULE_04
        (edge_o && rise_i && $past(rise_i) && $past(connect_i))
            |-> ($past(pin_i) == 1'h0 && pin_i == 1'h1))
        else $error("rising edge without 0 then 1");

    arm_first_a: assert property ( // RULE_02
        edge_o |-> $past(connect_i) && !$past(asserted_o) && !freeze_i)
        else $error("edge on a pin not seen deasserted");

endmodule : keli_pin_det

// [src/keli_pkg.sv]
package keli_pkg;

    // register byte offsets, one aligned word each
    localparam logic [3:0] KELI_CTRL_OFS = 4'h0;
    localparam logic [3:0] KELI_CONNECT_OFS = 4'h4;
    localparam logic [3:0] KELI_STATUS_OFS = 4'h8;
    localparam logic [3:0] KELI_MASK_OFS = 4'hC;

    // word index taken from haddr[3:2]
    localparam logic [1:0] KELI_CTRL_IDX = KELI_CTRL_OFS[3:2];
    localparam logic [1:0] KELI_CONNECT_IDX = KELI_CONNECT_OFS[3:2];
    localparam logic [1:0] KELI_STATUS_IDX = KELI_STATUS_OFS[3:2];
    localparam logic [1:0] KELI_MASK_IDX = KELI_MASK_OFS[3:2];

    // key_status_control field positions
    localparam int KELI_POL_LSB = 4;
    localparam int KELI_POL_W = 4;
    localparam int KELI_FLAG_BIT = 3;
    localparam int KELI_ACK_BIT = 2;
    localparam int KELI_IE_BIT = 1;
    localparam int KELI_MODE_BIT = 0;

    // interrupt status and mask bits
    localparam int KELI_EVT_W = 2;
    localparam int KELI_EVT_KEY = 0;
    localparam int KELI_EVT_WAKE = 1;

    // pins below this index are fixed falling/low sensitive
    localparam int KELI_FIXED_PINS = 4;
    localparam int KELI_MAX_PINS = 8;

    // ahb transfer type bit that marks NONSEQ/SEQ
    localparam int KELI_HTRANS_ACT = 1;

    // address-phase signals of the ahb-lite bus
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } keli_ahb_req_type;

    // whole state of the controller
    typedef struct packed {
        logic [KELI_POL_W-1:0] pol;
        logic flag;
        logic irq_en;
        logic mode;
        logic [KELI_MAX_PINS-1:0] connect;
        logic [KELI_EVT_W-1:0] status;
        logic [KELI_EVT_W-1:0] mask;
        logic wr_pend;
        logic wr_hit;
        logic [1:0] wr_idx;
        logic [31:0] rdata;
    } keli_state_type;

    localparam keli_state_type KELI_STATE_RST = '0;

    // state of one pin detector
    typedef struct packed {
        logic armed;
    } keli_det_state_type;

    localparam keli_det_state_type KELI_DET_RST = '0;

endpackage : keli_pkg

// [verification/keli_ctrl_tb.sv]
`timescale 1ns/1ps
module keli_ctrl_tb
    import keli_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic deep_stop = 1'b0;
    logic [7:0] level = 8'h0F;
    logic slow = 1'b0;
    logic [7:0] pins;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, key_irq_o, irq_o, wake_o;
    keli_ahb_req_type ahb_req;
    int err_count = 0;
    int num_checks = 0;
    localparam logic [31:0] CT = 32'h0000_0000;
    localparam logic [31:0] CN = 32'h0000_0004;
    localparam logic [31:0] ST = 32'h0000_0008;
    localparam logic [31:0] MK = 32'h0000_000C;

    always #4 clk_i = ~clk_i;
    // single slave, so its ready is the bus ready
    assign ahb_req = '{hsel: 1'b1, haddr: haddr, htrans: htrans,
        hwrite: hwrite, hsize: 3'h2, hready: hreadyout_o};

    keli_ctrl #(.N_PINS(8)) keli_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ahb_req_i(ahb_req), .hwdata_i(hwdata), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .key_input_pin_i(pins), .deep_stop_state_i(deep_stop),
        .key_irq_o(key_irq_o), .irq_o(irq_o), .wake_o(wake_o));
    keli_keypad_model #(.N_PINS(8)) keli_keypad_model_i (.clk_i(clk_i),
        .level_i(level), .slow_i(slow), .pins_o(pins));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : check

    // waits for hready at a rising edge, bounded
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_ready

    task automatic bus(input logic [31:0] a, input logic w,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata_o;
        check({31'h0, hresp_o}, 32'h0000_0000);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0000_0000, r);
        check(r, e);
    endtask : rd_chk

    // outputs packed as key_irq, irq, wake; looked at mid-cycle, since a
    // write that just landed only shows after its clock edge settles
    task automatic outs(input logic [31:0] e);
        @(negedge clk_i);
        check({29'h0, key_irq_o, irq_o, wake_o}, e);
    endtask : outs

    // model settles within three cycles, margin for detection
    task automatic pins_to(input logic [7:0] v);
        @(posedge clk_i);
        level <= v;
        repeat (6) @(posedge clk_i);
    endtask : pins_to

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_chk(CT, 32'h0000_0000);
        rd_chk(CN, 32'h0000_0000);
        rd_chk(ST, 32'h0000_0000);
        rd_chk(MK, 32'h0000_0000);
        rd_chk(32'h0000_0010, 32'h0000_0000);
        outs(32'h0000_0000);
        wr(CT, 32'h0000_00FF);
        rd_chk(CT, 32'h0000_00F3);
        wr(CT, 32'h0000_0002);
        $display("test registers done");
        pins_to(8'h0E);
        rd_chk(CT, 32'h0000_0002);
        pins_to(8'h0F);
        wr(CN, 32'h0000_0001);
        pins_to(8'h0E);
        rd_chk(CT, 32'h0000_000A);
        outs(32'h0000_0004);
        rd_chk(ST, 32'h0000_0001);
        wr(MK, 32'h0000_0001);
        outs(32'h0000_0006);
        wr(ST, 32'h0000_0001);
        outs(32'h0000_0004);
        wr(CT, 32'h0000_0006);
        rd_chk(CT, 32'h0000_0002);
        outs(32'h0000_0000);
        $display("test falling edge done");
        pins_to(8'h0D);
        wr(CN, 32'h0000_0003);
        pins_to(8'h0D);
        rd_chk(CT, 32'h0000_0002);
        pins_to(8'h0F);
        pins_to(8'h0D);
        rd_chk(CT, 32'h0000_000A);
        wr(CT, 32'h0000_0006);
        pins_to(8'h0F);
        $display("test arming done");
        slow <= 1'b1;
        wr(CT, 32'h0000_0012);
        wr(CN, 32'h0000_0010);
        pins_to(8'h1F);
        rd_chk(CT, 32'h0000_001A);
        wr(CT, 32'h0000_0016);
        pins_to(8'h0F);
        rd_chk(CT, 32'h0000_0012);
        wr(CT, 32'h0000_00F2);
        wr(CN, 32'h0000_0001);
        pins_to(8'h0E);
        rd_chk(CT, 32'h0000_00FA);
        wr(CT, 32'h0000_00F6);
        pins_to(8'h0F);
        slow <= 1'b0;
        $display("test polarity done");
        wr(CT, 32'h0000_0003);
        pins_to(8'h0E);
        wr(CT, 32'h0000_0007);
        rd_chk(CT, 32'h0000_000B);
        pins_to(8'h0F);
        wr(CT, 32'h0000_0007);
        rd_chk(CT, 32'h0000_0003);
        $display("test level mode done");
        wr(CT, 32'h0000_0002);
        wr(MK, 32'h0000_0003);
        wr(ST, 32'h0000_0003);
        @(posedge clk_i);
        deep_stop <= 1'b1;
        pins_to(8'h0E);
        outs(32'h0000_0003);
        @(posedge clk_i);
        deep_stop <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_chk(ST, 32'h0000_0002);
        wr(ST, 32'h0000_0002);
        outs(32'h0000_0000);
        $display("test deep stop done");
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_chk(CT, 32'h0000_0000);
        rd_chk(CN, 32'h0000_0000);
        outs(32'h0000_0000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : keli_ctrl_tb

// [verification/keli_keypad_model.sv]
`timescale 1ns/1ps
module keli_keypad_model #(
    parameter int N_PINS = 8
) (
    // clock
    input wire logic clk_i,
    // requested levels and response speed
    input wire logic [N_PINS-1:0] level_i,
    input wire logic slow_i,
    // key lines, pulled up when released
    output logic [N_PINS-1:0] pins_o
);
    logic [N_PINS-1:0] d0_reg = '1;
    logic [N_PINS-1:0] d1_reg = '1;
    logic [N_PINS-1:0] d2_reg = '1;
    // a slow key settles three cycles late, a prompt one after one
    always_ff @(posedge clk_i) begin
        d0_reg <= level_i;
        d1_reg <= d0_reg;
        d2_reg <= d1_reg;
    end
    assign pins_o = slow_i ? d2_reg : d0_reg;
endmodule : keli_keypad_model
